// ---- bench/digital_watchdog_downcounter_tb.sv ----
`timescale 1ns/1ns
module digital_watchdog_downcounter_tb;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        stop_req = 1'b0;
  logic        nmi_pin = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, stop_mode, wdog_reset, e, hw;
  logic [7:0]  r, d, mdl;
  int          err_count = 0;
  int          cmp_count = 0;
  int unsigned seed = 14;

  wdog_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_req(stop_req), .nmi_pin(nmi_pin), .stop_mode(stop_mode),
    .wdog_reset(wdog_reset));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    // No cycle count assumed; a hang is caught by the watchdog process
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register model: the active bit only ever sets until reset
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    apb(1'b1, a, wd);
    if (a == 8'hD8) mdl = {wd[7:1], wd[0] | mdl[0] | hw};
    else hw = wd[0];
    mdl[0] = mdl[0] | hw;
  endtask

  task automatic rd();
    apb(1'b0, 8'hD8, 8'h00);
    chk(r, mdl);
  endtask

  task automatic wait_rst(input int lo, input int hi);
    int n;
    n = 0;
    while (wdog_reset !== 1'b1 && n < hi) begin
      @(posedge sys_clk);
      n++;
    end
    chk({7'h0, wdog_reset === 1'b1 && n >= lo}, 8'h01);
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    mdl = 8'hFE;
    hw = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  task final_report;
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    do_reset();
    rd();
    apb(1'b0, 8'hE0, 8'h00);
    chk({7'h0, e}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      d = 8'(xs());
      wr(8'hD8, {d[7:2], 2'b10});
      rd();
    end
    // Timer mode: counter 0x40 steps to 0x3F after one prescaler period, no reset
    wr(8'hD8, 8'h02);
    repeat (3072) @(posedge sys_clk);
    mdl = 8'hFC;
    rd();
    chk({7'h0, wdog_reset}, 8'h00);
    // Count one in the top register bit: two prescaler periods
    wr(8'hD8, 8'h83);
    wr(8'hD8, 8'h82);
    rd();
    wait_rst(6130, 6150);
    do_reset();
    wr(8'hD8, 8'hFD);
    wait_rst(0, 3);
    do_reset();
    wr(8'hDC, 8'h01);
    wr(8'hD8, 8'hFE);
    rd();
    for (int k = 0; k < 3; k++) begin
      // Pin set before the request so its synchronised copy has settled
      nmi_pin <= k != 1;
      wr(8'hDC, k == 2 ? 8'h01 : 8'h03);
      stop_req <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk({7'h0, stop_mode}, {7'h0, k == 0});
      stop_req <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    final_report();
  end

  initial begin
    #(20000 * 40);
    err_count++;
    final_report();
  end
endmodule

// ---- bench/wdog_top_asserts.sv ----
`timescale 1ns/1ns
module wdog_top_asserts (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        stop_req,
  input wire logic        nmi_pin,
  input wire logic        stop_mode,
  input wire logic        wdog_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_ready_one_wait: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not idle");
  a_sr_clear_fires:
    assert property (psel && penable && pready && pwrite && paddr == 8'hD8 && !pwdata[1]
      |=> ##[0:2] wdog_reset) else $error("no reset after software reset write");
  a_pulse_four:
    assert property ($rose(wdog_reset) |-> wdog_reset[*4] ##1 !wdog_reset)
    else $error("reset pulse length");
  a_stop_needs_req: assert property (!stop_req |=> !stop_mode)
    else $error("stop without request");
  a_nmi_low_wait:
    assert property ((!nmi_pin)[*4] ##0 !stop_mode |=> !stop_mode)
    else $error("stop entered with pin low");
endmodule

bind wdog_top wdog_top_asserts chk (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .stop_req(stop_req), .nmi_pin(nmi_pin),
  .stop_mode(stop_mode), .wdog_reset(wdog_reset));

// ---- hdl/wdog_divider.sv ----
`timescale 1ns/1ns
module wdog_divider (
  input  wire logic sys_clk,
  input  wire logic rst_n_sync,
  input  wire logic restart,
  input  wire logic run,
  output logic      tick
);
  logic [wdog_pkg::TICK_W-1:0] count;

  // Tick every TICK_CYCLES while run is high; restart realigns the phase
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (restart) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (run) begin
      if (count == wdog_pkg::TICK_LAST) begin
        count <= '0;
        tick  <= 1'b1;
      end else begin
        count <= count + 1'b1;
        tick  <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end
endmodule

// ---- hdl/wdog_pkg.sv ----
package wdog_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WDOG       = 8'hD8;
  localparam logic [7:0] ADDR_OPTIONS    = 8'hDC;
  localparam logic [7:0] WDOG_RESET_VAL  = 8'hFE;
  localparam int         BIT_ACTIVE      = 0;
  localparam int         BIT_SW_RESET    = 1;
  localparam int         COUNT_LO_BIT    = 2;
  localparam int         COUNT_HI_BIT    = 7;
  localparam int         OPT_HW_BIT      = 0;
  localparam int         OPT_EXT_BIT     = 1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         TICK_OSC_CYCLES = 3072;
  localparam int         OSC_PER_SYS     = 1;
  localparam int         TICK_CYCLES     = TICK_OSC_CYCLES / OSC_PER_SYS;
  localparam int         TICK_W          = 12;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam int         RESET_PULSE_CYCLES = 4;
  localparam logic [2:0] RESET_PULSE_LAST   = 3'(RESET_PULSE_CYCLES - 1);

  typedef struct packed {
    logic hw_activation;
    logic ext_stop_ctrl;
  } options_t;

  typedef enum logic [1:0] {
    cpu_run,
    cpu_wait,
    cpu_stop
  } power_mode_t;

endpackage

// ---- hdl/wdog_top.sv ----
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
// Function
// - Any reset loads register with FE: inactive, software reset high, longest period; here only rst_b does, the module's own wdog_reset does not.
// - Software option: writing one activates; clearing ignored until reset.
// - Hardware option: activation bit forced to one always.
// - Writing zero to software-reset bit resets system immediately.
// - Register bit 7 is counter LSB, bit 2 is counter MSB.
// - Active watchdog resets when counter stage six falls to zero; no reset if an external stop freeze begins in that tick's cycle.
// - Six counter bits select 64 periods, 3072 to 196608 clocks.
// - Inactive: counter runs as free 7-bit timer, SR bit its MSB.
// - At least 28 instructions run after activation before any reset.
// - Hardware option without external stop: stop acts as wait.
// - External stop: NMI high freezes and stops; NMI low acts as wait.
module wdog_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_req,
  input  wire logic        nmi_pin,
  output logic             stop_mode,
  output logic             wdog_reset
);
  logic [1:0]            rst_pipe;
  logic                  rst_n_sync;
  logic [1:0]            nmi_pipe;
  logic                  nmi_level;
  wdog_pkg::options_t    options;
  logic [6:0]            counter;
  logic                  active;
  logic [2:0]            pulse_cnt;
  logic                  tick;
  logic                  access;
  logic                  wr_wdog;
  logic                  wr_opt;
  logic [7:0]            reg_view;
  logic [7:0]            wbyte;
  logic [6:0]            next_counter;
  logic                  freeze;
  logic                  fire;

  // ----------------------------------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_pipe[1];

  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      nmi_pipe <= 2'b00;
    end else begin
      nmi_pipe <= {nmi_pipe[0], nmi_pin};
    end
  end
  assign nmi_level = nmi_pipe[1];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign access  = psel && penable;
  assign wbyte   = pwdata[7:0];
  assign wr_wdog = access && pwrite && (paddr == wdog_pkg::ADDR_WDOG);
  assign wr_opt  = access && pwrite && (paddr == wdog_pkg::ADDR_OPTIONS);

  // reversed mapping, counter bit i sits at register bit 7-i
  always_comb begin
    reg_view = 8'h00;
    for (int i = 0; i < 6; i++) begin
      reg_view[wdog_pkg::COUNT_HI_BIT - i] = counter[i];
    end
    reg_view[wdog_pkg::BIT_SW_RESET] = counter[6];
    reg_view[wdog_pkg::BIT_ACTIVE]   = active;
  end

  always_comb begin
    next_counter = counter;
    for (int i = 0; i < 6; i++) begin
      next_counter[i] = wbyte[wdog_pkg::COUNT_HI_BIT - i];
    end
    next_counter[6] = wbyte[wdog_pkg::BIT_SW_RESET];
  end

  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == wdog_pkg::ADDR_WDOG) begin
          prdata <= {24'h00_0000, reg_view};
        end else if (paddr == wdog_pkg::ADDR_OPTIONS) begin
          prdata <= {30'h0000_0000, options.ext_stop_ctrl, options.hw_activation};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Options act as straps; writable only so software can configure the model
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      options <= '0;
    end else if (wr_opt && pready) begin
      options.hw_activation <= wbyte[wdog_pkg::OPT_HW_BIT];
      options.ext_stop_ctrl <= wbyte[wdog_pkg::OPT_EXT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Activation
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      active <= 1'b0;
    end else if (options.hw_activation) begin
      active <= 1'b1;
    end else if (wr_wdog && pready && wbyte[wdog_pkg::BIT_ACTIVE]) begin
      active <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power mode and prescaler
  // ----------------------------------------------------------------
  // without external control stop behaves as wait
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      stop_mode <= 1'b0;
    end else if (stop_req && options.ext_stop_ctrl && nmi_level) begin
      stop_mode <= 1'b1;
    end else if (!stop_req) begin
      stop_mode <= 1'b0;
    end
  end
  assign freeze = stop_mode || (stop_req && options.ext_stop_ctrl && nmi_level);

  // 3072-cycle tick, restarted by a reload
  wdog_divider u_div (
    .sys_clk    (sys_clk),
    .rst_n_sync (rst_n_sync),
    .restart    (wr_wdog && pready),
    .run        (!freeze),
    .tick       (tick)
  );

  // ----------------------------------------------------------------
  // Downcounter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      // all counter bits and SR set
      counter <= 7'h7F;
    end else if (wr_wdog && pready) begin
      counter <= next_counter;
    end else if (tick) begin
      // free 7-bit timer when inactive; period from count bits
      counter <= counter - 7'h01;
    end
  end

  // stage six falling; SR written to zero; holds since min period is 3072 cycles
  assign fire = (active && tick && !freeze && (counter == 7'h40))
             || (wr_wdog && pready && !wbyte[wdog_pkg::BIT_SW_RESET]);

  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      wdog_reset <= 1'b0;
      pulse_cnt  <= 3'h0;
    end else if (fire) begin
      wdog_reset <= 1'b1;
      pulse_cnt  <= 3'h0;
    end else if (wdog_reset) begin
      if (pulse_cnt == wdog_pkg::RESET_PULSE_LAST) begin
        wdog_reset <= 1'b0;
      end
      pulse_cnt <= pulse_cnt + 3'h1;
    end
  end
endmodule
